// ===== hw/lcd_link_if.sv
interface lcd_link_if;
  logic serial_clk;
  logic serial_in;
  logic serial_out;
  logic latch_pulse;
  logic col_only_n;
  modport device (
    input serial_clk,
    input serial_in,
    input latch_pulse,
    input col_only_n,
    output serial_out
  );
  modport host (
    output serial_clk,
    output serial_in,
    output latch_pulse,
    output col_only_n,
    input serial_out
  );
endinterface

// ===== hw/lcd_load_device.sv
module lcd_load_device #(
  parameter int MUX_ROWS = 8
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic arst_n,
  // Link.
  lcd_link_if.device link,
  // Display side.
  input wire logic [2:0] row_select,
  output logic [lcd_load_pkg::RAM_WIDTH-1:0] row_columns
);
  import lcd_load_pkg::*;
  logic [2:0] clk_sync;
  logic [2:0] latch_sync;
  logic [1:0] din_sync;
  logic [1:0] col_sync;
  logic [SHIFT_LEN-1:0] stages;
  logic dout;
  logic [RAM_WIDTH-1:0] ram [RAM_ROWS];
  logic [RAM_ROWS-1:0] addr;
  logic [RAM_WIDTH-1:0] cols;
  logic clk_fall;
  logic clk_rise;
  logic latch_fall;
  logic col_only;

  // Every pin passes two flops before logic reads it.
  // The third flop of the clock and latch chains only keeps the previous level,
  // so the edge detectors compare the second and third flops and never the first.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      clk_sync <= 3'h0;
    end else begin
      clk_sync <= {clk_sync[1:0], link.serial_clk};
    end
  end

  // The latch chain resets to the idle level, so no false fall follows reset.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      latch_sync <= 3'h0;
    end else begin
      latch_sync <= {latch_sync[1:0], link.latch_pulse};
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      din_sync <= 2'h0;
    end else begin
      din_sync <= {din_sync[0], link.serial_in};
    end
  end

  // The mode chain resets to the inactive level of the active-low pin.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      col_sync <= 2'h3;
    end else begin
      col_sync <= {col_sync[0], link.col_only_n};
    end
  end

  assign clk_fall = clk_sync[2] && !clk_sync[1];
  assign clk_rise = !clk_sync[2] && clk_sync[1];
  assign latch_fall = latch_sync[2] && !latch_sync[1];
  assign col_only = !col_sync[1];

  // The shift register powers up undefined in silicon; here it clears on reset.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stages <= '0;
    end else if (clk_fall) begin
      stages <= {stages[SHIFT_LEN-2:0], din_sync[1]};
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dout <= 1'b0;
    end else if (clk_rise) begin
      dout <= col_only ? stages[TAP_COL_ONLY] : stages[TAP_NORMAL];
    end
  end
  assign link.serial_out = dout;

  // Stage 0 holds word bit 0, so the low bits are the address.
  always_comb begin
    addr = '0;
    cols = '0;
    if (col_only) begin
      addr = stages[ADDR_BITS_COL_ONLY-1:0];
      cols = stages[SHIFT_LEN-1:ADDR_BITS_COL_ONLY];
    end else begin
      for (int k = 0; k < MUX_ROWS; k++) begin
        addr[RAM_ROWS-1-k] = stages[MUX_ROWS-1-k];
      end
      cols = {stages[RAM_WIDTH-1:MUX_ROWS], {MUX_ROWS{1'b0}}};
    end
  end

  // Address bit for row 0 is the first address bit sent, the MSB of addr.
  always_ff @(posedge clk_sys) begin
    for (int r = 0; r < RAM_ROWS; r++) begin
      if (latch_fall && addr[RAM_ROWS-1-r]) begin
        ram[r] <= cols;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      row_columns <= '0;
    end else begin
      row_columns <= ram[row_select];
    end
  end
endmodule

// ===== hw/lcd_load_host.sv
module lcd_load_host (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic arst_n,
  // Word stream from the user.
  input wire logic word_valid,
  output logic word_ready,
  input wire logic [lcd_load_pkg::FIFO_WIDTH-1:0] word_data,
  input wire logic word_col_only,
  // Link.
  lcd_link_if.host link
);
  import lcd_load_pkg::*;
  logic fifo_valid;
  logic fifo_pop;
  logic [FIFO_WIDTH-1:0] fifo_data;
  host_state_type state;
  logic [FIFO_WIDTH-1:0] shreg;
  logic [5:0] bit_cnt;
  logic [5:0] div_cnt;
  logic sclk;
  logic sdata;
  logic latch;
  logic col_only_n;

  lcd_word_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .in_valid(word_valid),
    .in_ready(word_ready),
    .in_data(word_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  assign fifo_pop = (state == host_idle) && fifo_valid;
  assign link.serial_clk = sclk;
  assign link.serial_in = sdata;
  assign link.latch_pulse = latch;
  assign link.col_only_n = col_only_n;

  // The host presents data on the rising serial clock edge so the device,
  // which samples on the falling edge, sees a full half period of setup.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state <= host_idle;
      shreg <= '0;
      bit_cnt <= RESET_COUNT;
      div_cnt <= RESET_COUNT;
      sclk <= 1'b0;
      sdata <= 1'b0;
      latch <= 1'b0;
      col_only_n <= 1'b1;
    end else begin
      unique case (state)
        host_idle: begin
          sclk <= 1'b0;
          latch <= 1'b0;
          div_cnt <= RESET_COUNT;
          if (fifo_valid) begin
            col_only_n <= !word_col_only;
            shreg <= word_col_only ? fifo_data : {fifo_data[WORD_NORMAL-1:0], 8'h00};
            bit_cnt <= word_col_only ? 6'(WORD_COL_ONLY) : 6'(WORD_NORMAL);
            state <= host_shift;
          end
        end
        host_shift: begin
          if (div_cnt == 6'(CLK_DIV_HALF - 1)) begin
            div_cnt <= RESET_COUNT;
            sclk <= !sclk;
            if (!sclk) begin
              sdata <= shreg[FIFO_WIDTH-1];
              shreg <= {shreg[FIFO_WIDTH-2:0], 1'b0};
            end else begin
              bit_cnt <= bit_cnt - 6'h01;
              if (bit_cnt == 6'h01) begin
                state <= host_latch;
              end
            end
          end else begin
            div_cnt <= div_cnt + 6'h01;
          end
        end
        host_latch: begin
          latch <= 1'b1;
          div_cnt <= div_cnt + 6'h01;
          if (div_cnt == 6'(2 * CLK_DIV_HALF)) begin
            div_cnt <= RESET_COUNT;
            latch <= 1'b0;
            state <= host_gap;
          end
        end
        host_gap: begin
          div_cnt <= div_cnt + 6'h01;
          if (div_cnt == 6'(2 * CLK_DIV_HALF)) begin
            div_cnt <= RESET_COUNT;
            state <= host_idle;
          end
        end
      endcase
    end
  end
endmodule

// ===== hw/lcd_load_pkg.sv
package lcd_load_pkg;
  localparam int WORD_NORMAL = 40;
  localparam int WORD_COL_ONLY = 48;
  localparam int SHIFT_LEN = 48;
  localparam int RAM_ROWS = 8;
  localparam int RAM_WIDTH = 40;
  localparam int ADDR_BITS_COL_ONLY = 8;
  localparam int TAP_NORMAL = 39;
  localparam int TAP_COL_ONLY = 47;
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_WIDTH = 48;
  localparam int CLK_DIV_HALF = 4;
  localparam logic [5:0] RESET_COUNT = 6'h00;
  typedef enum logic [1:0] {
    host_idle = 2'b00,
    host_shift = 2'b01,
    host_latch = 2'b10,
    host_gap = 2'b11
  } host_state_type;
endpackage

// ===== hw/lcd_word_fifo.sv
module lcd_word_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 32
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic arst_n,
  // Fill side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic push;
  logic pop;
  logic [AW:0] next_wr_ptr;
  logic [AW:0] next_rd_ptr;
  assign next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
  assign next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
  // Ready is registered so that the owner can hand it out straight from a flop.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      in_ready <= 1'b1;
    end else begin
      in_ready <= (next_wr_ptr - next_rd_ptr) != (AW + 1)'(DEPTH);
    end
  end
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data = mem[rd_ptr[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= '0;
    end else if (push) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rd_ptr <= '0;
    end else if (pop) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule

// ===== tb/lcd_link_chk.sv
module lcd_link_chk (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic arst_n,
  // Link.
  input wire logic serial_clk,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic latch_pulse,
  input wire logic col_only_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sclk_q;
  logic fall;
  logic [47:0] hist;
  logic [5:0] bits;
  assign fall = sclk_q & ~serial_clk;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // The history starts at zero because the device clears its stages on reset.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sclk_q <= 1'h0;
      hist <= 48'h0;
    end else begin
      sclk_q <= serial_clk;
      if (fall) begin
        hist <= {hist[46:0], serial_in};
      end
    end
  end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      bits <= 6'h00;
    end else if (latch_pulse) begin
      bits <= 6'h00;
    end else if (fall) begin
      bits <= bits + 6'h01;
    end
  end
  out_delay_a: assert property (fall |-> serial_out == (col_only_n ? hist[39] : hist[47]))
    else $error("forwarded bit wrong");
  word_len_a: assert property ($rose(latch_pulse) |-> bits == (col_only_n ? 6'h28 : 6'h30))
    else $error("word length wrong");
  out_edge_a: assert property ($changed(serial_out) |-> serial_clk)
    else $error("output moved while clock low");
  in_stable_a: assert property (fall |-> $stable(serial_in))
    else $error("data moved at falling edge");
  clk_high_a: assert property ($rose(serial_clk) |-> serial_clk[*4] ##1 !serial_clk)
    else $error("clock high phase wrong");
  latch_width_a: assert property ($rose(latch_pulse) |-> latch_pulse[*8] ##1 !latch_pulse)
    else $error("latch width wrong");
  latch_quiet_a: assert property (latch_pulse |-> !serial_clk)
    else $error("clock during latch");
  latch_gap_a: assert property ($fell(latch_pulse) |-> (!serial_clk)[*8])
    else $error("gap after latch too short");
  mode_hold_a: assert property (serial_clk |-> $stable(col_only_n))
    else $error("mode moved in word");
endmodule

// ===== tb/lcd_serial_load_ram_write_tb_top.sv
module lcd_serial_load_ram_write_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'h0;
  logic arst_n = 1'h0;
  logic word_valid = 1'h0;
  logic word_ready;
  logic [47:0] word_data = 48'h0;
  logic word_col_only = 1'h0;
  logic [2:0] row_select = 3'h0;
  logic [39:0] row_columns;
  int num_errors = 0;
  int tests_run = 0;
  int n = 0;
  lcd_link_if link ();
  lcd_load_host lcd_load_host_inst (.clk_sys, .arst_n, .word_valid, .word_ready, .word_data,
    .word_col_only, .link(link));
  lcd_load_device lcd_load_device_inst (.clk_sys, .arst_n, .link(link), .row_select,
    .row_columns);
  lcd_link_chk lcd_link_chk_inst (.clk_sys, .arst_n, .serial_clk(link.serial_clk),
    .serial_in(link.serial_in), .serial_out(link.serial_out),
    .latch_pulse(link.latch_pulse), .col_only_n(link.col_only_n));
  initial forever #12.5 clk_sys = ~clk_sys;
  task automatic give_verdict;
    if (num_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic push(input logic [47:0] w, input logic col);
    @(negedge clk_sys);
    word_valid = 1'h1;
    word_data = w;
    word_col_only = col;
    do @(posedge clk_sys); while (word_ready !== 1'h1);
    @(negedge clk_sys);
    word_valid = 1'h0;
  endtask
  task automatic load(input logic [47:0] w, input logic col);
    push(w, col);
    @(negedge link.latch_pulse);
    repeat (5) @(posedge clk_sys);
  endtask
  task automatic row(input logic [2:0] r, input logic [39:0] exp);
    @(negedge clk_sys);
    row_select = r;
    repeat (2) @(negedge clk_sys);
    check({8'h00, row_columns}, {8'h00, exp});
  endtask
  initial begin
    repeat (10) @(negedge clk_sys);
    arst_n = 1'h1;
    load(48'h00A5A55A5A80, 1'h0);
    row(3'h0, 40'hA5A55A5A00);
    load(48'h001234567801, 1'h0);
    row(3'h7, 40'h1234567800);
    row(3'h0, 40'hA5A55A5A00);
    load(48'h00FFFF0F0024, 1'h0);
    row(3'h2, 40'hFFFF0F0000);
    row(3'h5, 40'hFFFF0F0000);
    load(48'h00DEADBEEF00, 1'h0);
    row(3'h0, 40'hA5A55A5A00);
    load(48'hC30F0FF0F040, 1'h1);
    row(3'h1, 40'hC30F0FF0F0);
    // Zero-address words fill the buffer without touching the rows.
    while (word_ready === 1'h1 && n < 40) begin
      push(48'h5A5A5A5A5A00, 1'h1);
      n++;
    end
    check({47'h0, word_ready}, 48'h0);
    repeat (n) @(negedge link.latch_pulse);
    repeat (5) @(negedge clk_sys);
    check({47'h0, word_ready}, 48'h1);
    row(3'h1, 40'hC30F0FF0F0);
    give_verdict();
  end
  initial begin
    repeat (24000) @(posedge clk_sys);
    num_errors++;
    give_verdict();
  end
endmodule
